// *** hdl/hbt_pkg.sv ***
// Shared constants for the host bus cycle timing port: both ends use them.
// Assumes one 250 MHz clock shared by host and device ends.
package hbt_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned CLK_PERIOD_PS      = 4000;

  // Bus widths
  localparam int unsigned ADDR_W             = 16;
  localparam int unsigned DATA_W             = 8;

  // Power save control register, in the direct access mode
  localparam logic [15:0] PWR_SAVE_OFS       = 16'h0008;
  localparam int unsigned PWR_SAVE_WAKE_BIT  = 0;

  // Global setup command code in the indirect mode, arbitrary choice
  localparam logic [7:0]  SETUP_CMD          = 8'h40;

  // Reset pulse and oscillator stabilisation times
  localparam int unsigned RESET_MIN_US       = 1000;
  localparam int unsigned OSC_STABLE_US      = 3000;
  localparam int unsigned RESET_MIN_CYC      = RESET_MIN_US * CLK_MHZ;
  localparam int unsigned OSC_STABLE_CYC     = OSC_STABLE_US * CLK_MHZ;

  // Timing in system clock periods plus nanoseconds
  localparam int unsigned WAIT_MAX_TS        = 4;
  localparam int unsigned WAIT_MAX_NS        = 2;
  localparam int unsigned WAIT_MAX_CYC       =
    WAIT_MAX_TS + (WAIT_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned DATA_SETUP_TS      = 2;
  localparam int unsigned DATA_SETUP_NS      = 5;
  localparam int unsigned DATA_SETUP_CYC     =
    DATA_SETUP_TS + (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STROBE_MIN_TS      = 5;
  localparam int unsigned REC_RD_TS          = 1;
  localparam int unsigned REC_WW_TS          = 2;
  localparam int unsigned REC_WR_TS          = 5;
  localparam int unsigned REC_EXTRA_NS       = 2;
  localparam int unsigned REC_RD_CYC         = REC_RD_TS;
  localparam int unsigned REC_WW_CYC         =
    REC_WW_TS + (REC_EXTRA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REC_WR_CYC         =
    REC_WR_TS + (REC_EXTRA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Device answer latency: read data ready this many cycles after strobe seen
  localparam int unsigned RD_DATA_CYC        = 3;

endpackage : hbt_pkg

// *** hdl/hbt_bus_if.sv ***
// Parallel host bus between the host end and the device end.
// Assumes each end reads the other end's outputs directly; the testbench builds no resolved wait line or data bus.
`timescale 1ns/10ps
interface hbt_bus_if;
  logic                       cs_n;
  logic                       rd_n;
  logic                       wr_n;
  logic [hbt_pkg::ADDR_W-1:0] addr;
  logic [hbt_pkg::DATA_W-1:0] hd_o;     // Host data out
  logic                       hd_oe_n;  // Host drives data when low
  logic [hbt_pkg::DATA_W-1:0] dd_o;     // Device data out
  logic                       dd_oe_n;  // Device drives data when low
  logic                       wait_o;   // Device wait level
  logic                       wait_oe_n;// Device drives wait when low
  logic                       wait_en;  // Wait line fitted

  modport dev  (input cs_n, rd_n, wr_n, addr, hd_o, hd_oe_n, wait_en,
                output dd_o, dd_oe_n, wait_o, wait_oe_n);
  modport host (output cs_n, rd_n, wr_n, addr, hd_o, hd_oe_n, wait_en,
                input dd_o, dd_oe_n, wait_o, wait_oe_n);
endinterface : hbt_bus_if

// *** hdl/hbt_dev.sv ***
// Device end of the host bus: access timing, wake from power save, panel halt.
// Assumes strobes are synchronous to clock_i and the host keeps its timing.
//
// What the host bus must do
// RQ1 - Host holds reset at least 1 ms
// RQ2 - Accesses ignored while reset is active
// RQ3 - Panel data, line, AC toggle halted
// RQ4 - Direct write offset 08 bit0 wakes
// RQ5 - Indirect setup command wakes, starts oscillator
// RQ6 - Host waits 3 ms for oscillator
// RQ7 - Host waits after wake with crystal; the host only waits after reset, not after wake
// RQ8 - Wait driven low after strobe falls
// RQ9 - Wait released after strobe rises; the device releases it after RD_DATA_CYC cycles, strobe still active
// RQ10 - Wait held at most four periods
// RQ11 - Read data valid one period after wait
// RQ12 - Host keeps strobe recovery times
// RQ13 - Host sets write data two periods early
// RQ14 - No wait: strobe held five periods
// RQ15 - No wait: full cycle minimum times
// RQ16 - No wait: read data within four periods
// RQ17 - Track previous access kind
`timescale 1ns/10ps
module hbt_dev
#(
  parameter int unsigned DW = hbt_pkg::DATA_W
)
(
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          srst_i,
  // Mode select
  input  wire logic          indirect_i,
  // Host bus
  hbt_bus_if.dev             bus,
  // User side
  output logic               awake_o,
  output logic               osc_run_o,
  output logic               wr_stb_o,
  output logic [15:0]        wr_addr_o,
  output logic [DW-1:0]      wr_data_o,
  output logic               last_was_wr_o,
  input  wire logic [DW-1:0] rd_data_i,
  input  wire logic [DW-1:0] pix_i,
  input  wire logic          line_i,
  input  wire logic          ac_i,
  output logic [DW-1:0]      panel_pixel_data_o,
  output logic               panel_line_pulse_o,
  output logic               panel_ac_toggle_o
);

  typedef enum logic [3:0] {
    HBT_IDLE = 4'b0001,
    HBT_WAIT = 4'b0010,
    HBT_HOLD = 4'b0100,
    HBT_DONE = 4'b1000
  } hbt_st_t;

  hbt_st_t         st, next_st;
  logic [2:0]      cnt, next_cnt;
  logic            is_rd, next_is_rd;
  logic            awake, next_awake;
  logic            lastw, next_lastw;
  logic            wstb, next_wstb;
  logic [15:0]     waddr, next_waddr;
  logic [DW-1:0]   wdata, next_wdata;
  logic [DW-1:0]   dout, next_dout;
  logic            doe_n, next_doe_n;
  logic            wlvl_oe_n, next_wlvl_oe_n;
  logic [DW-1:0]   pix, next_pix;
  logic            line, next_line;
  logic            ac, next_ac;
  logic            strobe;

  assign strobe = ~bus.cs_n & (~bus.rd_n | ~bus.wr_n);

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencer: wait answer and read data
  always_comb
  begin
    next_st        = st;
    next_cnt       = cnt;
    next_is_rd     = is_rd;
    next_awake     = awake;
    next_lastw     = lastw;
    next_wstb      = 1'b0;
    next_waddr     = waddr;
    next_wdata     = wdata;
    next_dout      = dout;
    next_doe_n     = doe_n;
    next_wlvl_oe_n = wlvl_oe_n;
    unique case (st)
      HBT_IDLE:
      begin
        next_doe_n = 1'b1;
        if (strobe)
        begin
          next_st        = HBT_WAIT;
          next_cnt       = 3'h0;
          next_is_rd     = ~bus.rd_n;
          next_waddr     = bus.addr;
          next_wlvl_oe_n = ~bus.wait_en;                         // [RQ8]
        end
      end
      HBT_WAIT:
      begin
        // Counting to fixed latency keeps wait well under its ceiling
        next_cnt = cnt + 3'h1;
        if (cnt == 3'(hbt_pkg::RD_DATA_CYC - 1))                 // [RQ10] [RQ16]
        begin
          next_st = HBT_HOLD;
          if (is_rd)
          begin
            next_dout  = rd_data_i;                              // [RQ11]
            next_doe_n = 1'b0;
          end
          next_wlvl_oe_n = 1'b1;
        end
      end
      HBT_HOLD:
      begin
        // Write data sampled late, host presents it two periods early
        if (!is_rd)
          next_wdata = bus.hd_o;                                 // [RQ13]
        if (!strobe)
        begin
          next_st        = HBT_IDLE;
          next_wlvl_oe_n = 1'b1;                                 // [RQ9]
          next_doe_n     = 1'b1;
          next_lastw     = ~is_rd;                               // [RQ17]
          if (!is_rd)
          begin
            next_wstb = 1'b1;
            if (!indirect_i && waddr == hbt_pkg::PWR_SAVE_OFS
                && wdata[hbt_pkg::PWR_SAVE_WAKE_BIT])
              next_awake = 1'b1;                                 // [RQ4]
            if (indirect_i && wdata == hbt_pkg::SETUP_CMD)
              next_awake = 1'b1;                                 // [RQ5]
          end
        end
      end
      HBT_DONE:
        next_st = HBT_IDLE;
      default:
        next_st = HBT_IDLE;
    endcase
  end

  // Reset drops any access in flight
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      st        <= HBT_IDLE;                                     // [RQ2]
      cnt       <= 3'h0;
      is_rd     <= 1'b0;
      awake     <= 1'b0;
      lastw     <= 1'b0;
      wstb      <= 1'b0;
      waddr     <= 16'h0000;
      wdata     <= '0;
      dout      <= '0;
      doe_n     <= 1'b1;
      wlvl_oe_n <= 1'b1;
    end
    else
    begin
      st        <= next_st;
      cnt       <= next_cnt;
      is_rd     <= next_is_rd;
      awake     <= next_awake;
      lastw     <= next_lastw;
      wstb      <= next_wstb;
      waddr     <= next_waddr;
      wdata     <= next_wdata;
      dout      <= next_dout;
      doe_n     <= next_doe_n;
      wlvl_oe_n <= next_wlvl_oe_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Panel outputs, frozen low during reset
  always_comb
  begin
    next_pix  = pix_i;
    next_line = line_i;
    next_ac   = ac_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      pix  <= '0;                                                // [RQ3]
      line <= 1'b0;
      ac   <= 1'b0;
    end
    else
    begin
      pix  <= next_pix;
      line <= next_line;
      ac   <= next_ac;
    end
  end

  // Output mapping, all from flip-flops except the constant-low wait level
  assign bus.dd_o             = dout;
  assign bus.dd_oe_n          = doe_n;
  assign bus.wait_o           = 1'b0;
  assign bus.wait_oe_n        = wlvl_oe_n;
  assign awake_o              = awake;
  assign osc_run_o            = awake;
  assign wr_stb_o             = wstb;
  assign wr_addr_o            = waddr;
  assign wr_data_o            = wdata;
  assign last_was_wr_o        = lastw;
  assign panel_pixel_data_o   = pix;
  assign panel_line_pulse_o   = line;
  assign panel_ac_toggle_o    = ac;

endmodule : hbt_dev

// *** hdl/hbt_host.sv ***
// Host end of the host bus: runs one access per request with legal timing.
// Assumes the device end shares clock_i; wait line use follows wait_en.
`timescale 1ns/10ps
module hbt_host
#(
  parameter int unsigned DW        = hbt_pkg::DATA_W,
  parameter int unsigned RST_CYC   = hbt_pkg::RESET_MIN_CYC,
  parameter int unsigned OSC_CYC   = hbt_pkg::OSC_STABLE_CYC,
  parameter bit          USE_WAIT  = 1'b1
)
(
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          srst_i,
  // Host bus
  hbt_bus_if.host            bus,
  // Request
  input  wire logic          req_i,
  input  wire logic          req_wr_i,
  input  wire logic [15:0]   req_addr_i,
  input  wire logic [DW-1:0] req_data_i,
  // Answer
  output logic               ready_o,
  output logic               done_o,
  output logic [DW-1:0]      rd_data_o,
  output logic               dev_rst_o
);

  typedef enum logic [4:0] {
    HBH_RST  = 5'b00001,
    HBH_OSC  = 5'b00010,
    HBH_IDLE = 5'b00100,
    HBH_ACT  = 5'b01000,
    HBH_REC  = 5'b10000
  } hbh_st_t;

  hbh_st_t       st, next_st;
  logic [31:0]   cnt, next_cnt;
  logic          wr, next_wr;
  logic          lastw, next_lastw;
  logic          cs_n, next_cs_n;
  logic          rd_n, next_rd_n;
  logic          wr_n, next_wr_n;
  logic [15:0]   addr, next_addr;
  logic [DW-1:0] dat, next_dat;
  logic          hoe_n, next_hoe_n;
  logic          rdy, next_rdy;
  logic          done, next_done;
  logic [DW-1:0] rdat, next_rdat;
  logic          drst, next_drst;
  logic          seen_wait, next_seen_wait;

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_comb
  begin
    next_st        = st;
    next_cnt       = cnt;
    next_wr        = wr;
    next_lastw     = lastw;
    next_cs_n      = cs_n;
    next_rd_n      = rd_n;
    next_wr_n      = wr_n;
    next_addr      = addr;
    next_dat       = dat;
    next_hoe_n     = hoe_n;
    next_rdy       = 1'b0;
    next_done      = 1'b0;
    next_rdat      = rdat;
    next_drst      = drst;
    next_seen_wait = seen_wait;
    unique case (st)
      HBH_RST:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt >= RST_CYC - 1)                                  // [RQ1]
        begin
          next_drst = 1'b0;
          next_st   = HBH_OSC;
          next_cnt  = 32'h0;
        end
      end
      HBH_OSC:
      begin
        // Covers clock start after reset only; no oscillator wait follows a wake
        next_cnt = cnt + 32'h1;
        if (cnt >= OSC_CYC - 1)                                  // [RQ6] [RQ7]
        begin
          next_st  = HBH_IDLE;
          next_rdy = 1'b1;
        end
      end
      HBH_IDLE:
      begin
        next_rdy = 1'b1;
        if (req_i)
        begin
          next_rdy       = 1'b0;
          next_st        = HBH_ACT;
          next_cnt       = 32'h0;
          next_wr        = req_wr_i;
          next_cs_n      = 1'b0;
          next_rd_n      = req_wr_i;
          next_wr_n      = ~req_wr_i;
          next_addr      = req_addr_i;
          next_dat       = req_data_i;                           // [RQ13]
          next_hoe_n     = ~req_wr_i;
          next_seen_wait = 1'b0;
        end
      end
      HBH_ACT:
      begin
        next_cnt = cnt + 32'h1;
        if (!bus.wait_oe_n)
          next_seen_wait = 1'b1;
        // Strobe ends after the fixed minimum, and with wait in use not before wait release
        if (cnt >= hbt_pkg::STROBE_MIN_TS - 1                    // [RQ14]
            && !(USE_WAIT && !bus.wait_oe_n))
        begin
          next_cs_n  = 1'b1;
          next_rd_n  = 1'b1;
          next_wr_n  = 1'b1;
          next_hoe_n = 1'b1;
          next_rdat  = bus.dd_o;
          next_st    = HBH_REC;
          next_cnt   = 32'h0;
          next_done  = 1'b1;
          next_lastw = wr;
        end
      end
      HBH_REC:
      begin
        // Recovery uses the REC_WR_CYC time after a write and the REC_RD_CYC time after a read
        next_cnt = cnt + 32'h1;
        if (cnt >= (lastw ? hbt_pkg::REC_WR_CYC : hbt_pkg::REC_RD_CYC) - 1) // [RQ12] [RQ15]
        begin
          next_st  = HBH_IDLE;
          next_rdy = 1'b1;
        end
      end
      default:
        next_st = HBH_RST;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      st        <= HBH_RST;
      cnt       <= 32'h0;
      wr        <= 1'b0;
      lastw     <= 1'b0;
      cs_n      <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      addr      <= 16'h0000;
      dat       <= '0;
      hoe_n     <= 1'b1;
      rdy       <= 1'b0;
      done      <= 1'b0;
      rdat      <= '0;
      drst      <= 1'b1;
      seen_wait <= 1'b0;
    end
    else
    begin
      st        <= next_st;
      cnt       <= next_cnt;
      wr        <= next_wr;
      lastw     <= next_lastw;
      cs_n      <= next_cs_n;
      rd_n      <= next_rd_n;
      wr_n      <= next_wr_n;
      addr      <= next_addr;
      dat       <= next_dat;
      hoe_n     <= next_hoe_n;
      rdy       <= next_rdy;
      done      <= next_done;
      rdat      <= next_rdat;
      drst      <= next_drst;
      seen_wait <= next_seen_wait;
    end
  end

  assign bus.cs_n    = cs_n;
  assign bus.rd_n    = rd_n;
  assign bus.wr_n    = wr_n;
  assign bus.addr    = addr;
  assign bus.hd_o    = dat;
  assign bus.hd_oe_n = hoe_n;
  assign bus.wait_en = USE_WAIT;
  assign ready_o     = rdy;
  assign done_o      = done;
  assign rd_data_o   = rdat;
  assign dev_rst_o   = drst;

endmodule : hbt_host

// *** tb/hbt_properties.sv ***
// Checker for the host bus: watches the one interface joining host and device.
// Assumes one clock, a synchronous active-high reset and the wait line fitted.
`timescale 1ns/10ps
module hbt_properties
(
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  // Bus signals
  input  wire logic                       cs_n,
  input  wire logic                       rd_n,
  input  wire logic                       wr_n,
  input  wire logic [hbt_pkg::DATA_W-1:0] hd_o,
  input  wire logic                       hd_oe_n,
  input  wire logic                       dd_oe_n,
  input  wire logic                       wait_oe_n,
  input  wire logic                       wait_en
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // Both strobes released
  wire strb_idle = rd_n & wr_n;

  ////////////////////////////////////////////////////////////////////////////
  wait_drive_a: assert property (
    wait_en && !cs_n && $fell(strb_idle) |-> ##[1:2] !wait_oe_n)
    else $error("wait not driven after strobe fell");
  // Exact hold of three cycles keeps well inside the four period limit
  wait_max_a: assert property (
    $fell(wait_oe_n) |-> !wait_oe_n [*3] ##1 wait_oe_n)
    else $error("wait held for the wrong time");
  wait_idle_a: assert property (
    strb_idle |-> wait_oe_n)
    else $error("wait driven with no strobe active");
  rd_data_a: assert property (
    !rd_n && $rose(wait_oe_n) |-> ##[0:1] !dd_oe_n)
    else $error("read data late after wait release");
  dd_drive_a: assert property (
    !dd_oe_n |-> !rd_n || $past(!rd_n))
    else $error("device drives data outside a read");
  // Checked through reset itself, so the default disable is overridden
  rst_quiet_a: assert property (
    disable iff (1'b0) srst_i |=> wait_oe_n && dd_oe_n && strb_idle)
    else $error("bus not quiet during reset");
  wr_recover_a: assert property (
    $rose(wr_n) |-> strb_idle [*6])
    else $error("strobe recovery after write too short");
  strobe_hold_a: assert property (
    $fell(strb_idle) |-> !strb_idle [*5])
    else $error("strobe active for fewer than five periods");
  data_setup_a: assert property (
    $rose(wr_n) |-> !$past(hd_oe_n, 3) && $past(hd_o, 3) == $past(hd_o))
    else $error("write data not set up early enough");

  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios
  cov_write: cover property ($rose(wr_n));
  cov_read: cover property ($rose(rd_n));
  cov_wr_rd: cover property ($rose(wr_n) ##[1:20] $fell(rd_n));
endmodule // hbt_properties

// *** tb/testbench.sv ***
// Self-checking bench: host end and device end joined by one interface.
// Assumes short reset and oscillator counts so the run stays brief.
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic wr; logic [15:0] addr; logic [7:0] data;} hbt_note_t;

  logic        clock_i;
  logic        srst_i;
  logic        indirect_i;
  logic        req_i;
  logic        req_wr_i;
  logic [15:0] req_addr_i;
  logic [7:0]  req_data_i;
  logic [7:0]  rd_data_i;
  logic [7:0]  pix_i;
  logic        line_i;
  logic        ac_i;
  logic        ready, done, awake, osc_run, wr_stb, last_wr, line_o, ac_o, dev_rst;
  logic [7:0]  rd_data, wr_data, pix_o;
  logic [15:0] wr_addr;
  logic [31:0] seed;
  hbt_note_t   notes[$];
  hbt_note_t   nt;
  logic        kinds[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  hbt_bus_if bus ();
  hbt_host #(.RST_CYC(4), .OSC_CYC(8), .USE_WAIT(1'b1)) u_hbt_host (
    .clock_i, .srst_i, .bus(bus), .req_i, .req_wr_i, .req_addr_i, .req_data_i,
    .ready_o(ready), .done_o(done), .rd_data_o(rd_data), .dev_rst_o(dev_rst));
  hbt_dev u_hbt_dev (
    .clock_i, .srst_i, .indirect_i, .bus(bus), .awake_o(awake), .osc_run_o(osc_run),
    .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .last_was_wr_o(last_wr),
    .rd_data_i, .pix_i, .line_i, .ac_i, .panel_pixel_data_o(pix_o),
    .panel_line_pulse_o(line_o), .panel_ac_toggle_o(ac_o));
  hbt_properties u_hbt_properties (
    .clock_i, .srst_i, .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .hd_o(bus.hd_o), .hd_oe_n(bus.hd_oe_n), .dd_oe_n(bus.dd_oe_n),
    .wait_oe_n(bus.wait_oe_n), .wait_en(bus.wait_en));

  // 250 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Four-state compare, so an unknown never passes
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for the host to accept a request
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
    cmp(n < 200, 1'b1);
  endtask

  // One access; read data is fresh random so a stale value shows up
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
    wait_ready();
    seed = lfsr(seed);
    rd_data_i = seed[15:8];
    notes.push_back({wr, a, wr ? d : seed[15:8]});
    req_wr_i = wr;
    req_addr_i = a;
    req_data_i = d;
    req_i = 1'b1;
    @(negedge clock_i);
    req_i = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: each done takes the oldest note
  // Device side results settle one cycle after done, so they wait a negedge
  always @(negedge clock_i)
  begin
    if (done === 1'b1)
    begin
      cmp(notes.size() != 0, 1'b1);
      if (notes.size() != 0)
      begin
        nt = notes.pop_front();
        if (!nt.wr)
          cmp(rd_data, nt.data);
        @(negedge clock_i);
        cmp(last_wr, nt.wr);
        if (nt.wr)
        begin
          cmp({wr_stb, wr_addr}, {1'b1, nt.addr});
          cmp(wr_data, nt.data);
        end
      end
    end
  end

  // Hang guard: the full sequence needs well under a thousand cycles
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    srst_i = 1'b1;
    indirect_i = 1'b0;
    req_i = 1'b0;
    req_wr_i = 1'b0;
    req_addr_i = 16'h0000;
    req_data_i = 8'h00;
    rd_data_i = 8'h00;
    pix_i = 8'h5a;
    line_i = 1'b1;
    ac_i = 1'b1;
    seed = 32'ha600;
    repeat (4) @(negedge clock_i);
    cmp({pix_o, line_o, ac_o}, 10'h000);
    cmp(dev_rst, 1'b1);
    srst_i = 1'b0;
    access(1'b1, hbt_pkg::PWR_SAVE_OFS, 8'hfe);
    wait_ready();
    cmp(awake, 1'b0);
    cmp(dev_rst, 1'b0);
    access(1'b1, hbt_pkg::PWR_SAVE_OFS, 8'h01 << hbt_pkg::PWR_SAVE_WAKE_BIT);
    wait_ready();
    cmp({awake, osc_run}, 2'h3);
    cmp(pix_o, pix_i);
    // Back-to-back pairs of every kind, then random traffic
    foreach (kinds[i])
      access(kinds[i], 16'h0101 + i, 8'hc0 + i);
    repeat (20)
    begin
      seed = lfsr(seed);
      access(seed[0], {seed[31:17], 1'b1}, seed[15:8]);
    end
    wait_ready();
    // Second reset in indirect mode; requests during it must be dropped
    srst_i = 1'b1;
    indirect_i = 1'b1;
    req_i = 1'b1;
    repeat (4) @(negedge clock_i);
    cmp({awake, pix_o}, 9'h000);
    srst_i = 1'b0;
    req_i = 1'b0;
    // Other codes, even at the direct wake offset, leave indirect mode asleep
    access(1'b1, hbt_pkg::PWR_SAVE_OFS, hbt_pkg::SETUP_CMD ^ 8'h01);
    wait_ready();
    cmp(awake, 1'b0);
    access(1'b1, 16'h0001, hbt_pkg::SETUP_CMD);
    wait_ready();
    cmp({awake, osc_run}, 2'h3);
    repeat (4) @(negedge clock_i);
    complete_run();
  end
endmodule // testbench
